// ---- design/twm_master.sv ----
/*
  twm_master: three-wire serial eeprom master with apb register access,
  serial clock, data pin with output enable, chip select pin and interrupt.
  assumes: an apb master on clk; an external eeprom on the serial pins.
*/
// Summary of operation
// - serial clock near 500 kHz, cs pin
// - three-wire mode only when select equals 3
// - a control write in idle with count 0..8 starts one transfer
// - wait-for-ready holds busy until data rises
// - busy high whole transfer, fall raises interrupt
// - release bit floats data after last rise
// - read bit loads data register from eeprom
// - clock count field sets pulses, 0..8
// - read bits msb first, right justified
// - write bits msb first from top bit
// - zero count: no clocks, only drive/release
// - interrupt on busy fall, then read data
`timescale 1ns/1ps
`default_nettype none
module twm_master
    import twm_pkg::*;
#(
    parameter int HALF_CYC = TWM_HALF_CYC // system clocks per serial half period
) (
    input wire logic clk, // system clock, 125 MHz
    input wire logic rst, // async reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic serial_clk, // serial clock pin
    input wire logic serial_data_pin_in, // data pin level
    output logic serial_data_pin_out, // data pin drive value
    output logic serial_data_pin_oe, // data pin drive enable
    output logic chip_select, // general-purpose pin used as cs
    output logic transfer_done_interrupt // level interrupt
);
    typedef enum logic [1:0] {TWM_IDLE, TWM_LOW, TWM_HIGH, TWM_WAIT} twm_state_e;

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    twm_state_e state_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] serial_shift_data_reg;
    logic [1:0] eeprom_pin_select_reg;
    logic done_stat_reg;
    logic mask_reg;
    logic cs_reg;
    logic [3:0] bits_left_reg;
    logic [TWM_DIV_W-1:0] div_reg;
    logic sck_reg;
    logic dout_reg;
    logic oe_reg;
    logic busy_reg;
    logic busy_d_reg;
    logic din_s;
    logic din_d_reg;

    logic wr_acc;
    logic rd_setup;
    logic ctrl_wr;
    logic addr_ok;
    logic three_wire;
    logic div_end;
    logic busy_fall;
    logic data_rise;
    logic [3:0] cnt_w;

    // apb decode: single-cycle access, zero wait states
    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign three_wire = (eeprom_pin_select_reg == TWM_SEL_3WIRE);
    // a write while busy is refused so the running transfer stays intact
    assign ctrl_wr = wr_acc && (paddr == TWM_CTRL_OFS) && three_wire
                     && (state_reg == TWM_IDLE);
    assign cnt_w = pwdata[TWM_CNT_LSB +: TWM_CNT_W];

    always_comb begin
        unique case (paddr)
            TWM_CTRL_OFS, TWM_DATA_OFS, TWM_SEL_OFS,
            TWM_STAT_OFS, TWM_MASK_OFS, TWM_CS_OFS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // out-of-range clock count is flagged as an error, not clamped
    assign pslverr = psel && penable && (!addr_ok ||
                     (pwrite && paddr == TWM_CTRL_OFS && cnt_w > TWM_CNT_MAX));

    // ------------------------------------------------------------------
    // data pin synchroniser
    // ------------------------------------------------------------------
    twm_sync u_din_sync (
        .clk(clk),
        .rst(rst),
        .d(serial_data_pin_in),
        .q(din_s)
    );

    // edge history of the synchronised data line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            din_d_reg <= 1'b0;
        end else begin
            din_d_reg <= din_s;
        end
    end
    assign data_rise = din_s && !din_d_reg;

    // ------------------------------------------------------------------
    // software-owned configuration
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eeprom_pin_select_reg <= TWM_SEL_RST;
            mask_reg <= TWM_MASK_RST[0];
            cs_reg <= 1'b0;
        end else if (wr_acc) begin
            if (paddr == TWM_SEL_OFS) begin
                eeprom_pin_select_reg <= pwdata[1:0];
            end
            if (paddr == TWM_MASK_OFS) begin
                mask_reg <= pwdata[0];
            end
            if (paddr == TWM_CS_OFS) begin
                cs_reg <= pwdata[0]; // firmware frames the transaction
            end
        end
    end
    assign chip_select = cs_reg;

    // control register keeps the last written mode bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= TWM_CTRL_RST;
        end else if (ctrl_wr && cnt_w <= TWM_CNT_MAX) begin
            ctrl_reg <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // serial divider: half period ticks at about 1 MHz, giving a 500 kHz serial clock
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= '0;
        end else if (state_reg == TWM_IDLE || div_end) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end
    assign div_end = (div_reg == TWM_DIV_W'(HALF_CYC - 1));

    // ------------------------------------------------------------------
    // transfer state machine
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= TWM_IDLE;
            bits_left_reg <= '0;
            sck_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                TWM_IDLE: begin
                    sck_reg <= 1'b0; // idle low
                    if (ctrl_wr && cnt_w <= TWM_CNT_MAX) begin
                        bits_left_reg <= cnt_w;
                        if (cnt_w != 4'h0) begin
                            state_reg <= TWM_LOW;
                        end else if (pwdata[TWM_WFR_BIT]) begin
                            state_reg <= TWM_WAIT; // zero clocks
                        end
                    end
                end
                TWM_LOW: begin
                    if (div_end) begin
                        sck_reg <= 1'b1;
                        state_reg <= TWM_HIGH;
                    end
                end
                TWM_HIGH: begin
                    if (div_end) begin
                        sck_reg <= 1'b0;
                        bits_left_reg <= bits_left_reg - 4'h1;
                        if (bits_left_reg == 4'h1) begin
                            state_reg <= ctrl_reg[TWM_WFR_BIT] ? TWM_WAIT : TWM_IDLE;
                        end else begin
                            state_reg <= TWM_LOW;
                        end
                    end
                end
                TWM_WAIT: begin
                    if (data_rise) begin
                        state_reg <= TWM_IDLE; // eeprom ready
                    end
                end
            endcase
        end
    end
    assign serial_clk = sck_reg;

    // busy: set the cycle after the write, cleared when the sequence ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
            busy_d_reg <= 1'b0;
        end else begin
            busy_reg <= (state_reg != TWM_IDLE) || (ctrl_wr && cnt_w <= TWM_CNT_MAX
                        && (cnt_w != 4'h0 || pwdata[TWM_WFR_BIT]));
            busy_d_reg <= busy_reg;
        end
    end
    assign busy_fall = busy_d_reg && !busy_reg;

    // ------------------------------------------------------------------
    // data path: shift out on falling sck, sample on rising sck
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_shift_data_reg <= TWM_DATA_RST;
        end else if (wr_acc && paddr == TWM_DATA_OFS && state_reg == TWM_IDLE) begin
            serial_shift_data_reg <= pwdata[7:0];
        end else if (state_reg == TWM_LOW && div_end && ctrl_reg[TWM_RD_BIT]) begin
            // sample at the rising edge, shift left: ends right justified
            serial_shift_data_reg <= {serial_shift_data_reg[6:0], din_s};
        end else if (state_reg == TWM_HIGH && div_end && !ctrl_reg[TWM_RD_BIT]) begin
            serial_shift_data_reg <= {serial_shift_data_reg[6:0], 1'b0};
        end
    end

    // data pin drive and release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout_reg <= 1'b0;
            oe_reg <= 1'b1;
        end else if (ctrl_wr && cnt_w <= TWM_CNT_MAX) begin
            dout_reg <= serial_shift_data_reg[7]; // msb presented first
            if (cnt_w == 4'h0) begin
                oe_reg <= !pwdata[TWM_HIZ_BIT];
            end else begin
                oe_reg <= !pwdata[TWM_RD_BIT];
            end
        end else if (state_reg == TWM_LOW && div_end && bits_left_reg == 4'h1
                     && ctrl_reg[TWM_HIZ_BIT]) begin
            oe_reg <= 1'b0; // float right after the last rising edge
        end else if (state_reg == TWM_HIGH && div_end && !ctrl_reg[TWM_RD_BIT]) begin
            dout_reg <= serial_shift_data_reg[6]; // next bit after falling sck
        end
    end
    assign serial_data_pin_out = dout_reg;
    assign serial_data_pin_oe = oe_reg;

    // ------------------------------------------------------------------
    // interrupt: sticky done flag, write one to clear, set wins
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_stat_reg <= 1'b0;
        end else if (busy_fall) begin
            done_stat_reg <= 1'b1;
        end else if (wr_acc && paddr == TWM_STAT_OFS && pwdata[0]) begin
            done_stat_reg <= 1'b0;
        end
    end
    assign transfer_done_interrupt = done_stat_reg && mask_reg;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // captured in the setup cycle: data leaves a flip-flop and the access
    // phase needs no wait state; a flag set during access shows next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            unique case (paddr)
                TWM_CTRL_OFS: prdata <= {24'h00_0000, ctrl_reg[7], busy_reg, ctrl_reg[5:0]};
                TWM_DATA_OFS: prdata <= {24'h00_0000, serial_shift_data_reg};
                TWM_SEL_OFS: prdata <= {30'h0000_0000, eeprom_pin_select_reg};
                TWM_STAT_OFS: prdata <= {31'h0000_0000, done_stat_reg};
                TWM_MASK_OFS: prdata <= {31'h0000_0000, mask_reg};
                TWM_CS_OFS: prdata <= {31'h0000_0000, cs_reg};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- design/twm_pkg.sv ----
/*
  twm_pkg: register map, field positions, reset values and timing constants
  for the three-wire serial eeprom master.
  assumes: a 125 MHz system clock and 32-bit apb register access.
*/
package twm_pkg;
    // ------------------------------------------------------------------
    // register offsets (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] TWM_CTRL_OFS = 8'h00;
    localparam logic [7:0] TWM_DATA_OFS = 8'h04;
    localparam logic [7:0] TWM_SEL_OFS = 8'h08;
    localparam logic [7:0] TWM_STAT_OFS = 8'h0C;
    localparam logic [7:0] TWM_MASK_OFS = 8'h10;
    localparam logic [7:0] TWM_CS_OFS = 8'h14;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int TWM_WFR_BIT = 7;
    localparam int TWM_BUSY_BIT = 6;
    localparam int TWM_HIZ_BIT = 5;
    localparam int TWM_RD_BIT = 4;
    localparam int TWM_CNT_LSB = 0;
    localparam int TWM_CNT_W = 4;
    localparam logic [3:0] TWM_CNT_MAX = 4'h8;

    // pin selection value that enables three-wire operation
    localparam logic [1:0] TWM_SEL_3WIRE = 2'h3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] TWM_CTRL_RST = 8'h00;
    localparam logic [7:0] TWM_DATA_RST = 8'h00;
    localparam logic [1:0] TWM_SEL_RST = 2'h0;
    localparam logic [0:0] TWM_MASK_RST = 1'h0;

    // ------------------------------------------------------------------
    // timing: serial clock at 500 kHz from a 125 MHz clock
    // ------------------------------------------------------------------
    localparam int TWM_CLK_HZ = 125_000_000;
    localparam int TWM_SCK_HZ = 500_000;
    localparam int TWM_HALF_CYC = TWM_CLK_HZ / (2 * TWM_SCK_HZ);
    localparam int TWM_DIV_W = 8;
endpackage

// ---- design/twm_sync.sv ----
/*
  twm_sync: two flip-flop synchroniser for one level.
  assumes: the input is asynchronous to clk; only q is read downstream.
*/
`timescale 1ns/1ps
`default_nettype none
module twm_sync (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic d, // asynchronous level
    output logic q // synchronised level
);
    logic meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ---- dv/twm_eeprom_model.sv ----
/*
  twm_eeprom_model: behavioural three-wire eeprom on the serial pins.
  assumes: sck and cs come from the master; the bench feeds line back to it.
*/
`timescale 1ns/1ps
`default_nettype none
module twm_eeprom_model (
    input wire logic clk, // system clock, times the float pattern
    input wire logic sck, // serial clock from the master
    input wire logic cs, // chip select from the master
    input wire logic m_out, // master drive value
    input wire logic m_oe, // master drive enable
    input wire logic busy_hold, // hold the line low: internal write running
    input wire logic [7:0] tx_byte, // byte sent back on reads
    output logic line, // resolved data line level
    output logic [7:0] rx_byte // bits captured from the master
);
    logic [7:0] tx_sh;
    logic sck_q, oe_q, line_q, ee_oe;
    logic flt = 1'b0;
    // ---------------------------------------------------------------
    // line resolution; an undriven line toggles so no stale bit survives
    // ---------------------------------------------------------------
    assign ee_oe = cs && !m_oe;
    assign line = m_oe ? m_out : (ee_oe ? (busy_hold ? 1'b0 : tx_sh[7]) : flt);
    // reload while deselected, shift after each falling edge, capture at rise
    always @(posedge clk) begin
        flt <= ~flt;
        sck_q <= sck;
        oe_q <= m_oe;
        line_q <= line;
        if (!cs) begin
            tx_sh <= tx_byte;
        end else if (sck_q && !sck && !m_oe) begin
            tx_sh <= {tx_sh[6:0], 1'b0};
        end
        if (!sck_q && sck && oe_q) begin
            rx_byte <= {rx_byte[6:0], line_q};
        end
    end
endmodule
`default_nettype wire

// ---- dv/twm_master_asserts.sv ----
/*
  twm_master_asserts: port-level checks for the three-wire master.
  assumes: bound into twm_master; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module twm_master_asserts
    import twm_pkg::*;
#(
    parameter int HALF_CYC = TWM_HALF_CYC // serial half period in clocks
) (
    input wire logic clk, // system clock
    input wire logic rst, // async reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic serial_clk, // serial clock
    input wire logic serial_data_pin_in, // data level
    input wire logic serial_data_pin_out, // data drive value
    input wire logic serial_data_pin_oe, // data drive enable
    input wire logic chip_select, // cs pin
    input wire logic transfer_done_interrupt // interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] hi_cnt;
    logic ctrl_wr, cs_wr, mask_wr;
    // ---------------------------------------------------------------
    // helpers: decoded writes and serial clock high time
    // ---------------------------------------------------------------
    assign ctrl_wr = psel && penable && pwrite && paddr == TWM_CTRL_OFS;
    assign cs_wr = psel && penable && pwrite && paddr == TWM_CS_OFS;
    assign mask_wr = psel && penable && pwrite && paddr == TWM_MASK_OFS;
    // a wrong divider shows up as a short or long high phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_cnt <= 8'h00;
        end else begin
            hi_cnt <= serial_clk ? hi_cnt + 8'h01 : 8'h00;
        end
    end
    sequence s_mask_off;
        mask_wr && !pwdata[0];
    endsequence
    sequence s_irq_low;
        !transfer_done_interrupt [*2];
    endsequence
    property p_sck_high; $fell(serial_clk) |-> hi_cnt == 8'(HALF_CYC); endproperty
    a_sck_high: assert property (p_sck_high) else $error("sck high time wrong");
    property p_out_stable;
        serial_clk && $past(serial_clk) && serial_data_pin_oe && $past(serial_data_pin_oe)
            |-> $stable(serial_data_pin_out);
    endproperty
    a_out_stable: assert property (p_out_stable) else $error("dout moved in high");
    property p_cnt_err; ctrl_wr && pwdata[3:0] > TWM_CNT_MAX |-> pslverr; endproperty
    a_cnt_err: assert property (p_cnt_err) else $error("count over 8 accepted");
    property p_unmapped; psel && penable && paddr > TWM_CS_OFS |-> pslverr && pready; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
    property p_mask_off; s_mask_off |=> ##1 s_irq_low; endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked irq still high");
    property p_oe_fall;
        $fell(serial_data_pin_oe) |-> $rose(serial_clk) || $past(ctrl_wr) || $past(ctrl_wr, 2);
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("driver release mistimed");
    property p_oe_rise;
        $rose(serial_data_pin_oe) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("driver taken without write");
    property p_cs_cause; $changed(chip_select) |-> $past(cs_wr) || $past(cs_wr, 2); endproperty
    a_cs_cause: assert property (p_cs_cause) else $error("cs moved by itself");
    property p_upper_zero; psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits set");
    property p_irq_rise;
        $rose(transfer_done_interrupt) && !$past(mask_wr) && !$past(mask_wr, 2) |-> !serial_clk;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt during clocking");
endmodule
bind twm_master twm_master_asserts #(.HALF_CYC(HALF_CYC)) u_chk (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_clk(serial_clk),
    .serial_data_pin_in(serial_data_pin_in), .serial_data_pin_out(serial_data_pin_out),
    .serial_data_pin_oe(serial_data_pin_oe), .chip_select(chip_select),
    .transfer_done_interrupt(transfer_done_interrupt));
`default_nettype wire

// ---- dv/three_wire_eeprom_master_tb.sv ----
/*
  three_wire_eeprom_master_tb: self-checking bench, apb master plus eeprom model.
  assumes: twm_pkg offsets; half period 5 clocks gives an 80 ns serial clock.
*/
`timescale 1ns/1ps
`default_nettype none
module three_wire_eeprom_master_tb;
    import twm_pkg::*;
    localparam int HC = 5;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
    logic sck, din, dout, doe, cs, irq, hold;
    logic [7:0] paddr, tx_byte, rx_byte, d, m;
    logic [31:0] pwdata, prdata, rdata;
    int n_errors = 0;
    int n_tests = 0;
    int n_sck = 0;
    int n;
    twm_master #(.HALF_CYC(HC)) uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_clk(sck), .serial_data_pin_in(din),
        .serial_data_pin_out(dout), .serial_data_pin_oe(doe), .chip_select(cs),
        .transfer_done_interrupt(irq));
    twm_eeprom_model ee (.clk(clk), .sck(sck), .cs(cs), .m_out(dout), .m_oe(doe),
        .busy_hold(hold), .tx_byte(tx_byte), .line(din), .rx_byte(rx_byte));
    // ---------------------------------------------------------------
    // clock, pulse counter, shared tasks
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // counts pulses per transfer; cleared by xfer
    always @(posedge sck) n_sck++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("BAD %0t got %h exp %h", $time, got, exp);
            n_errors++;
        end
    endtask
    // one apb transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] ctl, input logic [7:0] dat);
        apb(1'b1, TWM_DATA_OFS, {24'h00_0000, dat});
        n_sck = 0;
        apb(1'b1, TWM_CTRL_OFS, {24'h00_0000, ctl});
    endtask
    task automatic wait_irq(input logic e, input int lim);
        for (int i = 0; i < lim && irq !== e; i++) @(posedge clk);
        chk(irq, e);
    endtask
    // expected bits: the top k bits of v, right justified
    function automatic logic [7:0] top_bits(input logic [7:0] v, input int k);
        return (k == 0) ? 8'h00 : v >> (8 - k);
    endfunction
    task automatic summarize;
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, hold} = 4'h0;
        {paddr, tx_byte, pwdata} = '0;
        d = 8'($urandom(71193));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a <= 20; a += 4) begin
            apb(1'b0, 8'(a), 32'h0000_0000);
            chk(rdata, 32'h0000_0000);
        end
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk(rerr, 1'b1);
        xfer(8'h08, 8'hA5);
        repeat (4 * HC) @(posedge clk);
        chk(n_sck, 0);
        apb(1'b1, TWM_SEL_OFS, 32'h0000_0003);
        apb(1'b1, TWM_MASK_OFS, 32'h0000_0001);
        apb(1'b1, TWM_CS_OFS, 32'h0000_0001);
        // the pin updates at the access edge itself; look one edge later
        @(posedge clk);
        chk(cs, 1'b1);
        // writes of counts 1 to 8 with random data
        for (n = 1; n <= 8; n++) begin
            d = 8'($urandom);
            m = 8'hFF >> (8 - n);
            xfer(8'(n), d);
            apb(1'b0, TWM_CTRL_OFS, 32'h0000_0000);
            chk(rdata[TWM_BUSY_BIT], 1'b1);
            wait_irq(1'b1, 30 * HC);
            chk(n_sck, n);
            chk(rx_byte & m, top_bits(d, n));
            apb(1'b1, TWM_STAT_OFS, 32'h0000_0001);
            wait_irq(1'b0, 4);
        end
        xfer(8'h09, 8'hFF);
        chk(rerr, 1'b1);
        repeat (4 * HC) @(posedge clk);
        chk(n_sck, 0);
        // reads of counts 1 to 8, each its own transaction
        for (n = 1; n <= 8; n++) begin
            m = 8'hFF >> (8 - n);
            apb(1'b1, TWM_CS_OFS, 32'h0000_0000);
            tx_byte <= 8'($urandom);
            apb(1'b1, TWM_CS_OFS, 32'h0000_0001);
            xfer(8'h10 | 8'(n), 8'h00);
            wait_irq(1'b1, 30 * HC);
            chk(doe, 1'b0);
            apb(1'b0, TWM_DATA_OFS, 32'h0000_0000);
            chk(rdata, 32'(top_bits(tx_byte, n)));
            apb(1'b1, TWM_STAT_OFS, 32'h0000_0001);
            apb(1'b1, TWM_CS_OFS, 32'h0000_0000);
            xfer(8'h00, 8'h00);
            repeat (4) @(posedge clk);
            chk(doe, 1'b1);
            chk({irq, 8'(n_sck)}, 9'h000);
        end
        // release after last rise, then wait for the eeprom's ready edge
        tx_byte <= 8'hFF;
        hold <= 1'b1;
        apb(1'b1, TWM_CS_OFS, 32'h0000_0001);
        d = 8'($urandom);
        xfer(8'hA8, d);
        repeat (20 * HC) @(posedge clk);
        chk(doe, 1'b0);
        chk(irq, 1'b0);
        chk(rx_byte, d);
        hold <= 1'b0;
        wait_irq(1'b1, 20);
        apb(1'b1, TWM_MASK_OFS, 32'h0000_0000);
        wait_irq(1'b0, 4);
        apb(1'b1, TWM_MASK_OFS, 32'h0000_0001);
        wait_irq(1'b1, 4);
        apb(1'b1, TWM_STAT_OFS, 32'h0000_0001);
        wait_irq(1'b0, 4);
        xfer(8'h20, 8'h00);
        repeat (4) @(posedge clk);
        chk({doe, 8'(n_sck)}, 9'h000);
        // zero clocks with wait-for-ready: busy holds until the ready edge
        hold <= 1'b1;
        xfer(8'hA0, 8'h00);
        repeat (4 * HC) @(posedge clk);
        chk(irq, 1'b0);
        hold <= 1'b0;
        wait_irq(1'b1, 20);
        summarize();
    end
    // watchdog: the sequence needs well under 10k clocks
    initial begin
        #400000;
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
